/* rtl/read_dma_ext_cmd.sv */
`timescale 1ns/10ps
`include "read_dma_ext_map.svh"
module read_dma_ext_cmd #(
  parameter int WORDS = `WORDS_PER_SECTOR
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // DMA data port
  input wire logic i_dmack,
  output logic o_dmarq,
  output logic [15:0] o_dd,
  output logic o_dd_strobe,
  // Media source
  input wire logic i_media_valid,
  input wire logic [15:0] i_media_data,
  input wire logic i_media_err,
  input wire logic i_dev_fault,
  output logic o_media_take,
  output logic [47:0] o_media_lba,
  // Interrupt
  output logic o_irq
);
  localparam int NPAIR = 5;
  localparam int I_CNT = 1;
  localparam int I_LO = 2;
  localparam int I_MID = 3;
  localparam int I_HI = 4;
  localparam logic [7:0] PAIR_OFS [NPAIR] =
    '{`OFS_FEATURE, `OFS_COUNT, `OFS_ADDR_LO, `OFS_ADDR_MID, `OFS_ADDR_HI};
  localparam logic [8:0] WORDS_W = 9'(WORDS);

  read_dma_ext_pkg::apb_req_s req;
  read_dma_ext_pkg::dev_status_s stat;
  read_dma_ext_pkg::cmd_state_e state_ff;
  logic [7:0] cur_b [NPAIR];
  logic [7:0] prev_b [NPAIR];
  logic [15:0] load_val [NPAIR];
  logic [NPAIR-1:0] wr_pair;
  logic [NPAIR-1:0] load_pair;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [7:0] dev_sel_ff;
  logic [7:0] dev_ctrl_ff;
  logic [7:0] cfg_ff;
  logic [7:0] errbits_ff;
  logic err_ff;
  logic df_ff;
  logic hide_ff;
  logic [16:0] sec_left_ff;
  logic [8:0] words_left_ff;
  logic [47:0] lba_ff;
  logic word_full_ff;
  logic [15:0] dd_ff;
  logic dd_strobe_ff;
  logic take_ff;
  logic [1:0] irq_stat_ff;
  logic [1:0] irq_en_ff;
  logic irq_ff;
  logic busy;
  logic setup;
  logic wr_en;
  logic cmd_wr;
  logic dev_match;
  logic go_ok;
  logic go_bad;
  logic [15:0] count16;
  logic [16:0] sec_init;
  logic [47:0] lba48;
  logic take;
  logic fail_media;
  logic fail;
  logic xfer;
  logic done_ok;
  logic [31:0] rd_val;
  logic [1:0] nxt_irq_stat;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] pick_byte(input logic [7:0] cur, input logic [7:0] prev,
                                           input logic hob, input logic hide);
    pick_byte = hide ? 8'h00 : (hob ? prev : cur);
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a <= `OFS_CONFIG) && (a[1:0] == 2'h0);
  endfunction

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  assign req = '{addr: i_paddr, write: i_pwrite, wdata: i_pwdata};
  assign setup = i_psel && !i_penable;
  assign wr_en = i_psel && i_penable && pready_ff && req.write;
  assign busy = (state_ff == read_dma_ext_pkg::ST_RUN);

  // ----------------------------------------
  // Register pairs
  // ----------------------------------------
  // Failing sector into pairs
  assign load_val[0] = 16'h0000;
  assign load_val[I_CNT] = 16'h0000;
  assign load_val[I_LO] = {lba_ff[31:24], lba_ff[7:0]};
  assign load_val[I_MID] = {lba_ff[39:32], lba_ff[15:8]};
  assign load_val[I_HI] = {lba_ff[47:40], lba_ff[23:16]};

  for (genvar i = 0; i < NPAIR; i++)
  begin : g_pair
    // Command block frozen while busy
    assign wr_pair[i] = wr_en && !busy && (req.addr == PAIR_OFS[i]);
    assign load_pair[i] = fail && (i >= I_LO);
    byte_pair_reg u_pair (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_wr(wr_pair[i]),
      .i_wdata(req.wdata[7:0]),
      .i_load(load_pair[i]),
      .i_load_val(load_val[i]),
      .o_cur(cur_b[i]),
      .o_prev(prev_b[i])
    );
  end

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  // Sixteen-bit count
  assign count16 = {prev_b[I_CNT], cur_b[I_CNT]};
  assign sec_init = (count16 == 16'h0000) ? `SEC_ZERO_CNT : {1'b0, count16};
  assign lba48 = {prev_b[I_HI], prev_b[I_MID], prev_b[I_LO],
                  cur_b[I_HI], cur_b[I_MID], cur_b[I_LO]};
  assign cmd_wr = wr_en && !busy && (req.addr == `OFS_CMD);
  assign dev_match = (dev_sel_ff[`BIT_DEV] == cfg_ff[`CFG_DEV]);
  // Refused when packet capable
  // Missing addressing bit is refused rather than guessed
  assign go_ok = cmd_wr && dev_match && (req.wdata[7:0] == `CMD_READ_DMA_EXT)
                 && !cfg_ff[`CFG_PACKET] && dev_sel_ff[`BIT_LBA];
  assign go_bad = cmd_wr && dev_match && !go_ok;

  // ----------------------------------------
  // Transfer control
  // ----------------------------------------
  // Take blocked for a cycle so the source can drop its valid
  // No capture in a failing cycle, so no word is left stranded after abort
  assign take = busy && !word_full_ff && i_media_valid && !take_ff && !i_media_err
                && !i_dev_fault;
  assign fail_media = busy && !word_full_ff && i_media_valid && !take_ff && i_media_err;
  assign fail = fail_media || (busy && i_dev_fault);
  assign xfer = busy && word_full_ff && i_dmack;
  assign done_ok = xfer && (words_left_ff == 9'h001) && (sec_left_ff == 17'h00001) && !fail;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      state_ff <= read_dma_ext_pkg::ST_IDLE;
    else
    begin
      unique case (state_ff)
        read_dma_ext_pkg::ST_IDLE:
          if (go_ok)
            state_ff <= read_dma_ext_pkg::ST_RUN;
        read_dma_ext_pkg::ST_RUN:
          if (done_ok || fail)
            state_ff <= read_dma_ext_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sec_left_ff <= 17'h00000;
      words_left_ff <= 9'h000;
      lba_ff <= 48'h000000000000;
    end
    else if (go_ok)
    begin
      sec_left_ff <= sec_init;
      words_left_ff <= WORDS_W;
      lba_ff <= lba48;
    end
    else if (xfer && !fail)
    begin
      if (words_left_ff == 9'h001)
      begin
        words_left_ff <= WORDS_W;
        sec_left_ff <= sec_left_ff - 17'h00001;
        lba_ff <= lba_ff + 48'h000000000001;
      end
      else
        words_left_ff <= words_left_ff - 9'h001;
    end
  end

  // ----------------------------------------
  // Data word and DMA request
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      word_full_ff <= 1'b0;
      dd_ff <= 16'h0000;
      dd_strobe_ff <= 1'b0;
      take_ff <= 1'b0;
    end
    else
    begin
      take_ff <= take;
      dd_strobe_ff <= xfer && !fail;
      if (take)
      begin
        dd_ff <= i_media_data;
        word_full_ff <= 1'b1;
      end
      else if (xfer || fail)
        word_full_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // Status and error
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      errbits_ff <= `RST_BYTE;
      err_ff <= 1'b0;
      df_ff <= 1'b0;
    end
    else if (go_ok || done_ok)
    begin
      errbits_ff <= `RST_BYTE;
      err_ff <= 1'b0;
      df_ff <= 1'b0;
    end
    else if (go_bad || fail)
    begin
      errbits_ff <= fail_media ? (8'h01 << `BIT_UNC) : (8'h01 << `BIT_ABRT);
      err_ff <= 1'b1;
      df_ff <= fail && !fail_media;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      hide_ff <= 1'b0;
    else if (done_ok)
      hide_ff <= 1'b1;
    else if (|wr_pair || fail)
      hide_ff <= 1'b0;
  end

  assign stat.bsy = busy;
  assign stat.drdy = 1'b1;
  assign stat.df = df_ff;
  assign stat.drq = busy && word_full_ff;
  assign stat.err = err_ff;

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      dev_sel_ff <= `RST_BYTE;
      dev_ctrl_ff <= `RST_BYTE;
      cfg_ff <= `RST_BYTE;
      irq_en_ff <= 2'h0;
    end
    else if (wr_en)
    begin
      if (req.addr == `OFS_DEV_SEL && !busy)
        dev_sel_ff <= req.wdata[7:0] & `DEV_SEL_MASK;
      if (req.addr == `OFS_DEV_CTRL)
        dev_ctrl_ff <= req.wdata[7:0];
      if (req.addr == `OFS_CONFIG && !busy)
        cfg_ff <= req.wdata[7:0];
      if (req.addr == `OFS_IRQ_EN)
        irq_en_ff <= req.wdata[1:0];
    end
  end

  // ----------------------------------------
  // Interrupt
  // ----------------------------------------
  always_comb
  begin
    nxt_irq_stat = irq_stat_ff;
    if (wr_en && req.addr == `OFS_IRQ_CLR)
      nxt_irq_stat = nxt_irq_stat & ~req.wdata[1:0];
    // New event beats a clear in the same cycle
    if (done_ok)
      nxt_irq_stat[`IRQ_DONE] = 1'b1;
    if (go_bad || fail)
      nxt_irq_stat[`IRQ_FAIL] = 1'b1;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      irq_stat_ff <= 2'h0;
      irq_ff <= 1'b0;
    end
    else
    begin
      irq_stat_ff <= nxt_irq_stat;
      irq_ff <= |(nxt_irq_stat & irq_en_ff);
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_comb
  begin
    rd_val = 32'h00000000;
    unique case (req.addr)
      `OFS_COUNT:
        rd_val[7:0] = pick_byte(cur_b[I_CNT], prev_b[I_CNT], dev_ctrl_ff[`BIT_HOB], hide_ff);
      `OFS_ADDR_LO:
        rd_val[7:0] = pick_byte(cur_b[I_LO], prev_b[I_LO], dev_ctrl_ff[`BIT_HOB], hide_ff);
      `OFS_ADDR_MID:
        rd_val[7:0] = pick_byte(cur_b[I_MID], prev_b[I_MID], dev_ctrl_ff[`BIT_HOB], hide_ff);
      `OFS_ADDR_HI:
        rd_val[7:0] = pick_byte(cur_b[I_HI], prev_b[I_HI], dev_ctrl_ff[`BIT_HOB], hide_ff);
      `OFS_DEV_SEL: rd_val[7:0] = dev_sel_ff;
      `OFS_CMD: rd_val[7:0] = {stat.bsy, stat.drdy, stat.df, 1'b0, stat.drq, 2'b00, stat.err};
      `OFS_ERROR: rd_val[7:0] = errbits_ff;
      `OFS_DEV_CTRL: rd_val[7:0] = dev_ctrl_ff;
      `OFS_IRQ_STAT: rd_val[1:0] = irq_stat_ff;
      `OFS_IRQ_EN: rd_val[1:0] = irq_en_ff;
      `OFS_CONFIG: rd_val[7:0] = cfg_ff;
      default: rd_val = 32'h00000000;
    endcase
  end

  // One wait-free access phase; data latched in setup
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end
    else
    begin
      pready_ff <= setup;
      pslverr_ff <= setup && !is_mapped(req.addr);
      if (setup)
        prdata_ff <= rd_val;
    end
  end

  assign o_prdata = prdata_ff;
  assign o_pready = pready_ff;
  assign o_pslverr = pslverr_ff;
  assign o_dmarq = word_full_ff;
  assign o_dd = dd_ff;
  assign o_dd_strobe = dd_strobe_ff;
  assign o_media_take = take_ff;
  assign o_media_lba = lba_ff;
  assign o_irq = irq_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_GO_RUN: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    go_ok |=> busy && !err_ff)
    else $error("command 25h not started");
  AST_PACKET: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    cmd_wr && dev_match && cfg_ff[`CFG_PACKET] |=> !busy && err_ff && errbits_ff[`BIT_ABRT])
    else $error("packet device did not abort");
  AST_COUNT16: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    go_ok && count16 != 16'h0000 |=> sec_left_ff == {1'b0, $past(count16)})
    else $error("sector count not assembled");
  AST_ZERO_CNT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    go_ok && count16 == 16'h0000 |=> sec_left_ff == `SEC_ZERO_CNT)
    else $error("zero count not 65536");
  AST_LBA48: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    go_ok |=> o_media_lba == $past(lba48))
    else $error("start address wrong");
  AST_DEV_SKIP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    cmd_wr && !dev_match |=> !busy && $stable(errbits_ff))
    else $error("unselected device acted");
  AST_DONE_BSY: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    done_ok |=> !busy && o_dd_strobe ##1 !o_dd_strobe)
    else $error("busy after completion");
  AST_DONE_FLAGS: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    done_ok |=> !err_ff && !df_ff && !o_dmarq && irq_stat_ff[`IRQ_DONE])
    else $error("flags not cleared on completion");
  AST_HIDE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    setup && hide_ff && req.addr == `OFS_ADDR_LO |=> o_prdata == 32'h00000000)
    else $error("reserved field not zero");
  AST_ERR_ADDR: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    fail |=> cur_b[I_LO] == $past(lba_ff[7:0]) && prev_b[I_HI] == $past(lba_ff[47:40]))
    else $error("failing address not loaded");
  AST_DMA: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_dd_strobe |-> $past(o_dmarq) && $past(i_dmack))
    else $error("word moved without handshake");
endmodule

/* rtl/read_dma_ext_map.svh */
`ifndef READ_DMA_EXT_MAP_SVH
`define READ_DMA_EXT_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_FEATURE 8'h00
`define OFS_COUNT 8'h04
`define OFS_ADDR_LO 8'h08
`define OFS_ADDR_MID 8'h0C
`define OFS_ADDR_HI 8'h10
`define OFS_DEV_SEL 8'h14
`define OFS_CMD 8'h18
`define OFS_ERROR 8'h1C
`define OFS_DEV_CTRL 8'h20
`define OFS_IRQ_STAT 8'h24
`define OFS_IRQ_EN 8'h28
`define OFS_IRQ_CLR 8'h2C
`define OFS_CONFIG 8'h30

// ----------------------------------------
// Fields and values
// ----------------------------------------
`define CMD_READ_DMA_EXT 8'h25
`define BIT_LBA 6
`define BIT_DEV 4
`define BIT_HOB 7
`define BIT_ABRT 2
`define BIT_UNC 6
`define IRQ_DONE 0
`define IRQ_FAIL 1
`define CFG_DEV 0
`define CFG_PACKET 1
`define DEV_SEL_MASK 8'hF0
`define SEC_ZERO_CNT 17'h10000
`define RST_BYTE 8'h00
`define WORDS_PER_SECTOR 256
`endif

/* rtl/read_dma_ext_pkg.sv */
package read_dma_ext_pkg;
  typedef enum logic [0:0] {ST_IDLE, ST_RUN} cmd_state_e;
  typedef struct packed {
    logic [7:0] addr;
    logic write;
    logic [31:0] wdata;
  } apb_req_s;
  typedef struct packed {
    logic bsy;
    logic drdy;
    logic df;
    logic drq;
    logic err;
  } dev_status_s;
endpackage

/* rtl/byte_pair_reg.sv */
`timescale 1ns/10ps
`include "read_dma_ext_map.svh"
module byte_pair_reg (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Host write
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  // Internal load
  input wire logic i_load,
  input wire logic [15:0] i_load_val,
  // Bytes
  output logic [7:0] o_cur,
  output logic [7:0] o_prev
);
  logic [7:0] cur_ff;
  logic [7:0] prev_ff;

  // ----------------------------------------
  // Two-deep byte
  // ----------------------------------------
  // Shift on write
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cur_ff <= `RST_BYTE;
      prev_ff <= `RST_BYTE;
    end
    else if (i_load)
    begin
      cur_ff <= i_load_val[7:0];
      prev_ff <= i_load_val[15:8];
    end
    else if (i_wr)
    begin
      prev_ff <= cur_ff;
      cur_ff <= i_wdata;
    end
  end

  assign o_cur = cur_ff;
  assign o_prev = prev_ff;

  AST_PAIR_SHIFT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_wr && !i_load |=> o_prev == $past(o_cur) && o_cur == $past(i_wdata))
    else $error("pair did not shift on write");
endmodule

/* dv/dma_host_model.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Host DMA channel
// ----------------------------------------
module dma_host_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Device side
  input wire logic i_dmarq,
  input wire logic [15:0] i_dd,
  input wire logic i_slow,
  output logic o_dmack,
  // Words received
  output logic o_word_valid,
  output logic [15:0] o_word
);
  logic [1:0] wait_ff;
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_dmack <= 1'b0;
      o_word_valid <= 1'b0;
      o_word <= 16'h0000;
      wait_ff <= 2'h0;
    end
    else
    begin
      o_word_valid <= 1'b0;
      if (o_dmack && i_dmarq)
      begin
        o_word <= i_dd;
        o_word_valid <= 1'b1;
        o_dmack <= 1'b0;
        wait_ff <= 2'h0;
      end
      else if (i_dmarq && !o_dmack)
      begin
        // Slow host stalls three cycles
        if (!i_slow || wait_ff == 2'h3)
          o_dmack <= 1'b1;
        else
          wait_ff <= wait_ff + 2'h1;
      end
      else if (!i_dmarq)
      begin
        // Request withdrawn by an aborted command
        o_dmack <= 1'b0;
        wait_ff <= 2'h0;
      end
    end
  end
endmodule

/* dv/tb.sv */
`timescale 1ns/10ps
`include "read_dma_ext_map.svh"
module tb;
  localparam int WORDS = 4;
  logic i_clk, i_rst_n, i_psel, i_penable, i_pwrite, i_dmack;
  logic i_media_valid, i_media_err, i_dev_fault, slow, serr, wv;
  logic o_pready, o_pslverr, o_dmarq, o_dd_strobe, o_media_take, o_irq;
  logic [7:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, rdat;
  logic [15:0] o_dd, i_media_data, word, rnd, mrnd;
  logic [47:0] o_media_lba, lba;
  logic [15:0] exp_q[$];
  int errors, total_checks, takes, moved, err_at, strobes;

  read_dma_ext_cmd #(.WORDS(WORDS)) uut (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_dmack(i_dmack),
    .o_dmarq(o_dmarq), .o_dd(o_dd), .o_dd_strobe(o_dd_strobe),
    .i_media_valid(i_media_valid), .i_media_data(i_media_data),
    .i_media_err(i_media_err), .i_dev_fault(i_dev_fault),
    .o_media_take(o_media_take), .o_media_lba(o_media_lba), .o_irq(o_irq));
  dma_host_model host (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_dmarq(o_dmarq),
    .i_dd(o_dd), .i_slow(slow), .o_dmack(i_dmack), .o_word_valid(wv),
    .o_word(word));

  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [31:0] stat(input logic d, input logic f, input logic e);
    return {24'h0, 1'b0, d, f, 4'h0, e};
  endfunction

  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    total_checks++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic rdy;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    // Answer and read data taken at the edge that samples pready
    do
    begin
      @(posedge i_clk);
      rdy = o_pready;
      rdat = o_prdata;
      serr = o_pslverr;
    end while (rdy !== 1'b1);
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, 48'(e), 48'(rdat));
  endtask

  task automatic load(input logic [15:0] c, input logic [7:0] dv, input logic [7:0] cd);
    wr(`OFS_COUNT, 32'(c[15:8]));
    wr(`OFS_COUNT, 32'(c[7:0]));
    for (int i = 0; i < 3; i++)
    begin
      wr(`OFS_ADDR_LO + 8'(4 * i), 32'(lba[24 + 8 * i +: 8]));
      wr(`OFS_ADDR_LO + 8'(4 * i), 32'(lba[8 * i +: 8]));
    end
    wr(`OFS_DEV_SEL, 32'(dv));
    exp_q.delete();
    takes = 0;
    strobes = 0;
    moved = 0;
    wr(`OFS_CMD, 32'(cd));
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    do
    begin
      apb(1'b0, `OFS_CMD, 32'h0);
      n++;
    end while (rdat[7] !== 1'b0 && n < 3000);
    chk("bsy", 48'h0, 48'(rdat[7]));
  endtask

  // ----------------------------------------
  // Media source and word checks
  // ----------------------------------------
  always @(posedge i_clk)
  begin
    if (o_media_take)
    begin
      if (takes == 0)
        chk("start lba", lba, o_media_lba);
      exp_q.push_back(i_media_data);
      mrnd = lfsr(mrnd);
      i_media_data <= mrnd;
      takes++;
      i_media_err <= (takes + 1 == err_at);
    end
    if (o_dd_strobe)
      strobes++;
    if (wv)
    begin
      moved++;
      chk("dd word", 48'(exp_q.pop_front()), 48'(word));
    end
  end

  initial
  begin
    {i_psel, i_penable, i_pwrite, i_media_valid, i_media_err, i_dev_fault} = 6'h00;
    {i_rst_n, slow} = 2'b00;
    {i_paddr, i_pwdata, i_media_data} = 56'h0;
    {rnd, mrnd} = {16'h005C, 16'h005C};
    {errors, total_checks, err_at, lba} = '0;
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    i_media_valid <= 1'b1;
    rd("count reset", `OFS_COUNT, 32'h0);
    apb(1'b0, 8'h3C, 32'h0);
    chk("slverr", 48'h1, 48'(serr));
    for (int i = 0; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      wr(`OFS_COUNT + 8'(4 * i), 32'(rnd[15:8]));
      wr(`OFS_COUNT + 8'(4 * i), 32'(rnd[7:0]));
      wr(`OFS_DEV_CTRL, 32'h0);
      rd("pair cur", `OFS_COUNT + 8'(4 * i), 32'(rnd[7:0]));
      wr(`OFS_DEV_CTRL, 32'h80);
      rd("pair prev", `OFS_COUNT + 8'(4 * i), 32'(rnd[15:8]));
    end
    wr(`OFS_IRQ_EN, 32'h3);
    // Long count prompt, short count slow
    for (int k = 0; k < 2; k++)
    begin
      slow <= k[0];
      rnd = lfsr(rnd);
      lba = {rnd, ~rnd, rnd ^ 16'hA5C3};
      load(k ? 16'h0002 : 16'h0101, 8'h40, `CMD_READ_DMA_EXT);
      wait_idle();
      chk("words", 48'(k ? 2 * WORDS : 257 * WORDS), 48'(moved));
      chk("strobes", 48'(k ? 2 * WORDS : 257 * WORDS), 48'(strobes));
      rd("status ok", `OFS_CMD, stat(1'b1, 1'b0, 1'b0));
      rd("irq stat", `OFS_IRQ_STAT, 32'h1);
      chk("irq", 48'h1, 48'(o_irq));
      wr(`OFS_IRQ_CLR, 32'h1);
      repeat (2) @(negedge i_clk);
      chk("irq clr", 48'h0, 48'(o_irq));
      wr(`OFS_DEV_CTRL, 32'(k) << 7);
      rd("hidden", `OFS_ADDR_HI, 32'h0);
      rd("hidden lo", `OFS_ADDR_LO, 32'h0);
    end
    // Uncorrectable word in second sector
    err_at = WORDS + 2;
    load(16'h0003, 8'h40, `CMD_READ_DMA_EXT);
    wait_idle();
    i_media_err <= 1'b0;
    err_at = 0;
    rd("status err", `OFS_CMD, stat(1'b1, 1'b0, 1'b1));
    rd("unc", `OFS_ERROR, 32'h40);
    lba = lba + 48'h1;
    for (int i = 0; i < 3; i++)
    begin
      wr(`OFS_DEV_CTRL, 32'h0);
      rd("fail lo", `OFS_ADDR_LO + 8'(4 * i), 32'(lba[8 * i +: 8]));
      wr(`OFS_DEV_CTRL, 32'h80);
      rd("fail hi", `OFS_ADDR_LO + 8'(4 * i), 32'(lba[24 + 8 * i +: 8]));
    end
    // Zero count runs past a sector limit; fault ends it
    load(16'h0000, 8'h40, `CMD_READ_DMA_EXT);
    for (int n = 0; n < 12000 && takes < 257 * WORDS; n++)
      @(posedge i_clk);
    apb(1'b0, `OFS_CMD, 32'h0);
    chk("zero count busy", 48'h1, 48'(rdat[7]));
    i_dev_fault <= 1'b1;
    wait_idle();
    i_dev_fault <= 1'b0;
    rd("status df", `OFS_CMD, stat(1'b1, 1'b1, 1'b1));
    rd("df abrt", `OFS_ERROR, 32'h04);
    wr(`OFS_IRQ_CLR, 32'h3);
    wr(`OFS_IRQ_EN, 32'h0);
    // Packet device, addressing bit clear, wrong code
    for (int i = 0; i < 3; i++)
    begin
      wr(`OFS_CONFIG, i == 0 ? 32'h2 : 32'h0);
      load(16'h0001, i == 1 ? 8'h00 : 8'h40, i == 2 ? 8'h24 : `CMD_READ_DMA_EXT);
      wait_idle();
      rd("abort status", `OFS_CMD, stat(1'b1, 1'b0, 1'b1));
      rd("abrt", `OFS_ERROR, 32'h04);
      chk("masked irq", 48'h0, 48'(o_irq));
    end
    wr(`OFS_IRQ_EN, 32'h2);
    repeat (2) @(negedge i_clk);
    chk("irq en", 48'h1, 48'(o_irq));
    wr(`OFS_IRQ_CLR, 32'h3);
    repeat (2) @(negedge i_clk);
    chk("irq off", 48'h0, 48'(o_irq));
    // Other device selected
    load(16'h0001, 8'h50, `CMD_READ_DMA_EXT);
    repeat (20) @(posedge i_clk);
    chk("no takes", 48'h0, 48'(takes));
    rd("dev sel", `OFS_DEV_SEL, 32'h50);
    stop_test();
  end

  initial
  begin
    repeat (60000) @(posedge i_clk);
    errors++;
    stop_test();
  end
endmodule
